// ---- mdc_pkg.sv ----
// package for the change-detection register slice: offsets, reset values, field positions, modes
// assumes the owner of the serial front end delivers decoded byte writes and reads on clk_i
package mdc_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_ORIENT_THS   = 8'h2c;
    localparam logic [7:0] OFS_OUT_FLAGS    = 8'h2d;
    localparam logic [7:0] OFS_WIN_FLAGS    = 8'h2e;
    localparam logic [7:0] OFS_CFG_A        = 8'h2f;
    localparam logic [7:0] OFS_CFG_B        = 8'h30;
    localparam logic [7:0] OFS_OUT_DBC      = 8'h31;
    localparam logic [7:0] OFS_WIN_DBC      = 8'h32;
    localparam logic [7:0] OFS_LTH_LO       = 8'h33;
    localparam logic [7:0] OFS_LTH_HI       = 8'h34;
    localparam logic [7:0] OFS_UTH_LO       = 8'h35;
    localparam logic [7:0] OFS_UTH_HI       = 8'h36;
    localparam logic [7:0] OFS_ST_IDLE      = 8'h37;
    localparam logic [7:0] OFS_ST_DECIM     = 8'h38;
    localparam logic [7:0] OFS_RSVD_A       = 8'h39;
    localparam logic [7:0] OFS_RSVD_B       = 8'h3a;

    // ************************************************************
    // reset values, strap low / strap high
    // ************************************************************
    localparam logic [7:0] RST_ORIENT_THS   = 8'h84;
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [7:0] RST_CFG_A_HI     = 8'h38;
    localparam logic [7:0] RST_CFG_B_HI     = 8'hd8;
    localparam logic [7:0] RST_LTH_LO_HI    = 8'hc0;
    localparam logic [7:0] RST_LTH_HI_HI    = 8'h0f;
    localparam logic [7:0] RST_UTH_LO_HI    = 8'h40;
    localparam logic [1:0] INIT_LAST        = 2'h3;  // last count of the four-edge strap settle

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned CFG_B_REFERENCE_UPDATE_BIT = 5;  // chosen position of reference_update
    localparam int unsigned THR_MSB_BITS      = 4;  // significant bits in a threshold high byte

    // operating modes as seen from the sensor core
    typedef enum logic [1:0] {
        MDC_STANDBY,
        MDC_ACTIVE,
        MDC_EXTERNAL_TRIGGER_MODE
    } mdc_mode_t;

    // one host byte access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mdc_acc_t;

    // event flags reported by the detection core
    typedef struct packed {
        logic [7:0] outside_threshold;
        logic [7:0] within_threshold;
    } mdc_evt_t;

endpackage : mdc_pkg

// ---- mdc_regs.sv ----
// register slice for orientation threshold, change detection and self-test timing
// assumes accesses, mode and events arrive synchronous to clk_i; strap is a pin and is synchronised
`timescale 1ns/1ns
`default_nettype none

module mdc_regs (
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic              boot_strap_pin_i,      // pin, asynchronous
    input  wire logic              hibernate_exit_i,      // pulse: leaving hibernate
    input  wire mdc_pkg::mdc_mode_t mode_i,
    input  wire logic              byte_order_select_i,   // 0 little-endian right-justified
    input  wire mdc_pkg::mdc_acc_t acc_i,
    input  wire mdc_pkg::mdc_evt_t evt_set_i,             // one-cycle set requests per flag bit
    output logic [7:0]             rdata_o,
    output logic [7:0]             orient_ths_o,
    output logic [7:0]             cfg_a_o,
    output logic [7:0]             cfg_b_o,
    output logic [7:0]             outside_dbc_o,
    output logic [7:0]             within_dbc_o,
    output logic [11:0]            lower_threshold_o,
    output logic [11:0]            upper_threshold_o,
    output logic [7:0]             st_idle_o,
    output logic [7:0]             st_decim_o,
    output logic [7:0]             outside_flags_o,
    output logic [7:0]             within_flags_o,
    output logic                   buffer_invalid_o       // pulse on entry to active or trigger
);

    // ************************************************************
    // strap synchroniser and mode tracking
    // ************************************************************
    logic [1:0]          strap_sync_q;
    mdc_pkg::mdc_mode_t  mode_q;
    logic                enter_run;
    logic                standby;
    logic                init_q;          // defaults still to be loaded from strap
    logic                load_dflt;

    // two flops before anyone looks at the strap
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_sync_q <= 2'b00;
        end else begin
            strap_sync_q <= {strap_sync_q[0], boot_strap_pin_i};
        end
    end

    // previous mode, to spot the standby-to-run edge
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_q <= mdc_pkg::MDC_STANDBY;
        end else begin
            mode_q <= mode_i;
        end
    end

    // strap-dependent defaults are loaded once the synchroniser has settled
    logic [1:0] init_cnt_q;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            init_cnt_q <= 2'b00;
            init_q     <= 1'b1;
        end else if (hibernate_exit_i) begin
            init_cnt_q <= 2'b00;
            init_q     <= 1'b1;
        end else if (init_cnt_q != mdc_pkg::INIT_LAST) begin
            init_cnt_q <= init_cnt_q + 2'b01;
        end else begin
            init_q     <= 1'b0;
        end
    end

    assign load_dflt = init_q || hibernate_exit_i;
    assign standby   = (mode_i == mdc_pkg::MDC_STANDBY);
    assign enter_run = (mode_q == mdc_pkg::MDC_STANDBY) && !standby;

    // default picker; strap high selects the second set
    function automatic logic [7:0] dflt(input logic hi, input logic [7:0] lo_v, input logic [7:0] hi_v);
        dflt = hi ? hi_v : lo_v;
    endfunction : dflt

    // write strobe for one offset, standby only; the reserved location is never writable
    function automatic logic wr_hit(input mdc_pkg::mdc_acc_t a, input logic [7:0] ofs, input logic sb);
        wr_hit = a.wr && (a.addr == ofs) && sb;
    endfunction : wr_hit

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [7:0] orient_ths_q;
    logic [7:0] cfg_a_q;
    logic [7:0] cfg_b_q;
    logic [7:0] out_dbc_q;
    logic [7:0] win_dbc_q;
    logic [7:0] lth_lo_q;
    logic [7:0] lth_hi_q;
    logic [7:0] uth_lo_q;
    logic [7:0] uth_hi_q;
    logic [7:0] st_idle_q;
    logic [7:0] st_decim_q;
    logic       hi;
    logic       cfg_b_ref_set;

    assign hi = strap_sync_q[1];
    // only reference_update may be raised while active
    assign cfg_b_ref_set = acc_i.wr && (acc_i.addr == mdc_pkg::OFS_CFG_B) &&
                           (mode_i == mdc_pkg::MDC_ACTIVE) &&
                           acc_i.wdata[mdc_pkg::CFG_B_REFERENCE_UPDATE_BIT];

    // values hold across active-to-standby because nothing but writes or defaults touches them
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            orient_ths_q <= mdc_pkg::RST_ORIENT_THS;
            out_dbc_q    <= mdc_pkg::RST_ZERO;
            win_dbc_q    <= mdc_pkg::RST_ZERO;
            st_idle_q    <= mdc_pkg::RST_ZERO;
            st_decim_q   <= mdc_pkg::RST_ZERO;
        end else if (load_dflt) begin
            orient_ths_q <= mdc_pkg::RST_ORIENT_THS;
            out_dbc_q    <= mdc_pkg::RST_ZERO;
            win_dbc_q    <= mdc_pkg::RST_ZERO;
            st_idle_q    <= mdc_pkg::RST_ZERO;
            st_decim_q   <= mdc_pkg::RST_ZERO;
        end else begin
            if (wr_hit(acc_i, mdc_pkg::OFS_ORIENT_THS, standby)) orient_ths_q <= acc_i.wdata;
            if (wr_hit(acc_i, mdc_pkg::OFS_OUT_DBC, standby))    out_dbc_q    <= acc_i.wdata;
            if (wr_hit(acc_i, mdc_pkg::OFS_WIN_DBC, standby))    win_dbc_q    <= acc_i.wdata;
            if (wr_hit(acc_i, mdc_pkg::OFS_ST_IDLE, standby))    st_idle_q    <= acc_i.wdata;
            if (wr_hit(acc_i, mdc_pkg::OFS_ST_DECIM, standby))   st_decim_q   <= acc_i.wdata;
        end
    end

    // change-detection configuration, strap-dependent defaults
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_a_q <= mdc_pkg::RST_ZERO;
            cfg_b_q <= mdc_pkg::RST_ZERO;
        end else if (load_dflt) begin
            cfg_a_q <= dflt(hi, mdc_pkg::RST_ZERO, mdc_pkg::RST_CFG_A_HI);
            cfg_b_q <= dflt(hi, mdc_pkg::RST_ZERO, mdc_pkg::RST_CFG_B_HI);
        end else begin
            if (wr_hit(acc_i, mdc_pkg::OFS_CFG_A, standby)) cfg_a_q <= acc_i.wdata;
            if (wr_hit(acc_i, mdc_pkg::OFS_CFG_B, standby)) begin
                cfg_b_q <= acc_i.wdata;
            end else if (cfg_b_ref_set) begin
                cfg_b_q[mdc_pkg::CFG_B_REFERENCE_UPDATE_BIT] <= 1'b1;
            end
        end
    end

    // twelve-bit thresholds; high bytes keep only the significant nibble
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lth_lo_q <= mdc_pkg::RST_ZERO;
            lth_hi_q <= mdc_pkg::RST_ZERO;
            uth_lo_q <= mdc_pkg::RST_ZERO;
            uth_hi_q <= mdc_pkg::RST_ZERO;
        end else if (load_dflt) begin
            lth_lo_q <= dflt(hi, mdc_pkg::RST_ZERO, mdc_pkg::RST_LTH_LO_HI);
            lth_hi_q <= dflt(hi, mdc_pkg::RST_ZERO, mdc_pkg::RST_LTH_HI_HI);
            uth_lo_q <= dflt(hi, mdc_pkg::RST_ZERO, mdc_pkg::RST_UTH_LO_HI);
            uth_hi_q <= mdc_pkg::RST_ZERO;
        end else begin
            if (wr_hit(acc_i, mdc_pkg::OFS_LTH_LO, standby)) lth_lo_q <= acc_i.wdata;
            if (wr_hit(acc_i, mdc_pkg::OFS_LTH_HI, standby)) lth_hi_q <= {4'h0, acc_i.wdata[3:0]};
            if (wr_hit(acc_i, mdc_pkg::OFS_UTH_LO, standby)) uth_lo_q <= acc_i.wdata;
            if (wr_hit(acc_i, mdc_pkg::OFS_UTH_HI, standby)) uth_hi_q <= {4'h0, acc_i.wdata[3:0]};
        end
    end

    // ************************************************************
    // event flags
    // ************************************************************
    logic [7:0] out_flags_q;
    logic [7:0] win_flags_q;

    // mode entry clears, but a set arriving in the same cycle still wins
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_flags_q <= mdc_pkg::RST_ZERO;
            win_flags_q <= mdc_pkg::RST_ZERO;
        end else if (load_dflt) begin
            out_flags_q <= mdc_pkg::RST_ZERO;
            win_flags_q <= mdc_pkg::RST_ZERO;
        end else if (enter_run) begin
            out_flags_q <= evt_set_i.outside_threshold;
            win_flags_q <= evt_set_i.within_threshold;
        end else begin
            out_flags_q <= out_flags_q | evt_set_i.outside_threshold;
            win_flags_q <= win_flags_q | evt_set_i.within_threshold;
        end
    end

    // buffer contents are stale after entering a run mode
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buffer_invalid_o <= 1'b0;
        end else begin
            buffer_invalid_o <= enter_run;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [7:0] rdata_d;
    logic [11:0] lth;
    logic [11:0] uth;

    assign lth = {lth_hi_q[3:0], lth_lo_q};
    assign uth = {uth_hi_q[3:0], uth_lo_q};

    // big-endian mode swaps bytes and left-justifies the twelve bits
    function automatic logic [7:0] thr_byte(input logic [11:0] v, input logic be, input logic upper);
        logic [15:0] w;
        w = be ? {v, 4'h0} : {4'h0, v};
        thr_byte = (upper ^ be) ? w[15:8] : w[7:0];
    endfunction : thr_byte

    // reserved location at 39h reads its fixed 00h; unmapped reads give zero
    always_comb begin
        rdata_d = 8'h00;
        case (acc_i.addr)
            mdc_pkg::OFS_ORIENT_THS: rdata_d = orient_ths_q;
            mdc_pkg::OFS_OUT_FLAGS:  rdata_d = out_flags_q;
            mdc_pkg::OFS_WIN_FLAGS:  rdata_d = win_flags_q;
            mdc_pkg::OFS_CFG_A:      rdata_d = cfg_a_q;
            mdc_pkg::OFS_CFG_B:      rdata_d = cfg_b_q;
            mdc_pkg::OFS_OUT_DBC:    rdata_d = out_dbc_q;
            mdc_pkg::OFS_WIN_DBC:    rdata_d = win_dbc_q;
            mdc_pkg::OFS_LTH_LO:     rdata_d = thr_byte(lth, byte_order_select_i, 1'b0);
            mdc_pkg::OFS_LTH_HI:     rdata_d = thr_byte(lth, byte_order_select_i, 1'b1);
            mdc_pkg::OFS_UTH_LO:     rdata_d = thr_byte(uth, byte_order_select_i, 1'b0);
            mdc_pkg::OFS_UTH_HI:     rdata_d = thr_byte(uth, byte_order_select_i, 1'b1);
            mdc_pkg::OFS_ST_IDLE:    rdata_d = st_idle_q;
            mdc_pkg::OFS_ST_DECIM:   rdata_d = st_decim_q;
            mdc_pkg::OFS_RSVD_A:     rdata_d = mdc_pkg::RST_ZERO;
            default:                 rdata_d = 8'h00;
        endcase
    end

    // registered read data, one cycle after the read request
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (acc_i.rd) begin
            rdata_o <= rdata_d;
        end
    end

    // ************************************************************
    // registered copies for the detection core
    // ************************************************************
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            orient_ths_o      <= mdc_pkg::RST_ORIENT_THS;
            cfg_a_o           <= 8'h00;
            cfg_b_o           <= 8'h00;
            outside_dbc_o     <= 8'h00;
            within_dbc_o      <= 8'h00;
            lower_threshold_o <= 12'h000;
            upper_threshold_o <= 12'h000;
            st_idle_o         <= 8'h00;
            st_decim_o        <= 8'h00;
            outside_flags_o   <= 8'h00;
            within_flags_o    <= 8'h00;
        end else begin
            orient_ths_o      <= orient_ths_q;
            cfg_a_o           <= cfg_a_q;
            cfg_b_o           <= cfg_b_q;
            outside_dbc_o     <= out_dbc_q;
            within_dbc_o      <= win_dbc_q;
            lower_threshold_o <= lth;
            upper_threshold_o <= uth;
            st_idle_o         <= st_idle_q;
            st_decim_o        <= st_decim_q;
            outside_flags_o   <= out_flags_q;
            within_flags_o    <= win_flags_q;
        end
    end

endmodule : mdc_regs

`default_nettype wire

// ---- mdc_regs_sva.sv ----
// checker for the change-detection register slice: mode protection, event flags, read layout
// assumes it is bound to mdc_regs and sees only that module's ports, one clock domain
`timescale 1ns/1ns
`default_nettype none
module mdc_regs_chk (
    input wire logic               clk_i,
    input wire logic               rstn_i,
    input wire mdc_pkg::mdc_mode_t mode_i,
    input wire logic               byte_order_select_i,
    input wire mdc_pkg::mdc_acc_t  acc_i,
    input wire mdc_pkg::mdc_evt_t  evt_set_i,
    input wire logic [7:0]         rdata_o,
    input wire logic [7:0]         orient_ths_o,
    input wire logic [7:0]         cfg_a_o,
    input wire logic [7:0]         cfg_b_o,
    input wire logic [7:0]         outside_flags_o,
    input wire logic [7:0]         within_flags_o,
    input wire logic               buffer_invalid_o
);
    // ************************************************************
    // port timing properties
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // all bits of config b except the reference update bit
    localparam logic [7:0] KEEP_B = ~(8'h01 << mdc_pkg::CFG_B_REFERENCE_UPDATE_BIT);
    // edge at which the core leaves standby
    sequence s_entry;
        mode_i != mdc_pkg::MDC_STANDBY && $past(mode_i) == mdc_pkg::MDC_STANDBY;
    endsequence
    // a write two edges back was outside standby, so the copies must not move now
    sequence s_frozen;
        $past(mode_i, 2) != mdc_pkg::MDC_STANDBY;
    endsequence
    property p_inv_entry; s_entry |=> buffer_invalid_o; endproperty
    a_inv_entry: assert property (p_inv_entry) else $error("no buffer invalid pulse on run entry");
    property p_inv_cause;
        buffer_invalid_o |-> $past(mode_i) != mdc_pkg::MDC_STANDBY && $past(mode_i, 2) == mdc_pkg::MDC_STANDBY;
    endproperty
    a_inv_cause: assert property (p_inv_cause) else $error("buffer invalid pulse without run entry");
    property p_flag_clear;
        s_entry ##0 evt_set_i == '0 ##1 evt_set_i == '0 |=> outside_flags_o == 8'h00 && within_flags_o == 8'h00;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("event flags survive run entry");
    property p_flag_set;
        evt_set_i.outside_threshold != 8'h00 |=> ##1
            (outside_flags_o & $past(evt_set_i.outside_threshold, 2)) == $past(evt_set_i.outside_threshold, 2);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("outside event not latched");
    property p_cfga_frozen; s_frozen |-> $stable(cfg_a_o); endproperty
    a_cfga_frozen: assert property (p_cfga_frozen) else $error("config a moved outside standby");
    property p_orient_frozen; s_frozen |-> $stable(orient_ths_o); endproperty
    a_orient_frozen: assert property (p_orient_frozen) else $error("orientation byte moved outside standby");
    property p_cfgb_frozen; s_frozen |-> (cfg_b_o & KEEP_B) == ($past(cfg_b_o) & KEEP_B); endproperty
    a_cfgb_frozen: assert property (p_cfgb_frozen) else $error("config b field moved outside standby");
    property p_rsvd_rd; acc_i.rd && acc_i.addr == mdc_pkg::OFS_RSVD_A ##1 !acc_i.rd |=> rdata_o == 8'h00; endproperty
    a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved byte not zero");
    property p_le_hi;
        acc_i.rd && acc_i.addr == mdc_pkg::OFS_LTH_HI && !byte_order_select_i ##1 !acc_i.rd |=> rdata_o[7:4] == 4'h0;
    endproperty
    a_le_hi: assert property (p_le_hi) else $error("little-endian high byte not right-justified");
    property p_be_lo;
        acc_i.rd && acc_i.addr == mdc_pkg::OFS_UTH_HI && byte_order_select_i ##1 !acc_i.rd |=> rdata_o[3:0] == 4'h0;
    endproperty
    a_be_lo: assert property (p_be_lo) else $error("big-endian low byte not left-justified");
    c_entry: cover property (s_entry);
    c_reference_update: cover property (s_frozen ##0 $rose(cfg_b_o[5]));
    c_be_read: cover property (acc_i.rd && byte_order_select_i);
endmodule : mdc_regs_chk
bind mdc_regs mdc_regs_chk chk_u (.clk_i(clk_i), .rstn_i(rstn_i), .mode_i(mode_i),
    .byte_order_select_i(byte_order_select_i), .acc_i(acc_i), .evt_set_i(evt_set_i), .rdata_o(rdata_o),
    .orient_ths_o(orient_ths_o), .cfg_a_o(cfg_a_o), .cfg_b_o(cfg_b_o), .outside_flags_o(outside_flags_o),
    .within_flags_o(within_flags_o), .buffer_invalid_o(buffer_invalid_o));
`default_nettype wire

// ---- mdc_host.sv ----
// host model: issues single-byte register writes and reads on the decoded access port
// assumes the bench calls its tasks just after a rising edge of clk_i
`timescale 1ns/1ns
`default_nettype none
module mdc_host (
    input  wire logic             clk_i,
    input  wire logic [7:0]       rdata_i,
    output var mdc_pkg::mdc_acc_t acc_o
);
    // idle bus from time zero
    initial acc_o = '0;
    // one-cycle write; the factory byte is never touched, so such a call is dropped here
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        if (addr == mdc_pkg::OFS_RSVD_A) return;
        @(posedge clk_i);
        #1 acc_o = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk_i);
        #1 acc_o = '0;
    endtask : wr_reg
    // one-cycle read; data is taken a full cycle later since rdata_o is registered
    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_i);
        #1 acc_o = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk_i);
        #1 acc_o = '0;
        @(posedge clk_i);
        #1 data = rdata_i;
    endtask : rd_reg
endmodule : mdc_host
`default_nettype wire

// ---- mdc_regs_tb.sv ----
// self-checking bench for the change-detection register slice
// assumes mdc_regs, mdc_host and the bound checker are compiled before it
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module mdc_regs_tb;
    // ************************************************************
    // stimulus and observation
    // ************************************************************
    logic               clk_i  = 1'b0;
    logic               rstn_i = 1'b0;
    logic               strap  = 1'b1;
    logic               hib    = 1'b0;
    logic               bos    = 1'b0;
    mdc_pkg::mdc_mode_t mode   = mdc_pkg::MDC_STANDBY;
    mdc_pkg::mdc_evt_t  evt    = '0;
    mdc_pkg::mdc_acc_t  acc;
    logic [7:0]         rdata, orient, cfg_a, cfg_b, oflags, wflags, rv;
    logic [7:0]         odbc, wdbc, sidle, sdecim;
    logic [11:0]        lth, uth;
    logic               binv;
    int                 err_count = 0;
    int                 tests_run = 0;
    // 4 ns clock
    always #2 clk_i = ~clk_i;
    mdc_regs dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .boot_strap_pin_i(strap), .hibernate_exit_i(hib),
        .mode_i(mode), .byte_order_select_i(bos), .acc_i(acc), .evt_set_i(evt), .rdata_o(rdata),
        .orient_ths_o(orient), .cfg_a_o(cfg_a), .cfg_b_o(cfg_b), .outside_dbc_o(odbc), .within_dbc_o(wdbc),
        .lower_threshold_o(lth), .upper_threshold_o(uth), .st_idle_o(sidle), .st_decim_o(sdecim),
        .outside_flags_o(oflags), .within_flags_o(wflags), .buffer_invalid_o(binv));
    mdc_host host_u (.clk_i(clk_i), .rdata_i(rdata), .acc_o(acc));
    // wait n edges, then land just after the last one
    task step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    // strap-high defaults of the whole slice, plus an unmapped byte
    task automatic t_defaults;
        logic [7:0] exp_tab [15] = '{8'h84, 8'h00, 8'h00, 8'h38, 8'hd8, 8'h00, 8'h00, 8'hc0,
                                     8'h0f, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 15; i++) begin
            host_u.rd_reg(mdc_pkg::OFS_ORIENT_THS + 8'(i), rv);
            `CHK(rv, exp_tab[i])
        end
        host_u.rd_reg(8'h50, rv);
        `CHK(rv, 8'h00)
        $display("test defaults done");
    endtask : t_defaults
    // thresholds in both byte orders, read-only flags, debounce and self-test bytes
    task t_rw;
        host_u.wr_reg(mdc_pkg::OFS_LTH_LO, 8'hab);
        host_u.wr_reg(mdc_pkg::OFS_LTH_HI, 8'hf5);
        host_u.wr_reg(mdc_pkg::OFS_UTH_LO, 8'h12);
        host_u.wr_reg(mdc_pkg::OFS_UTH_HI, 8'h03);
        host_u.wr_reg(mdc_pkg::OFS_OUT_FLAGS, 8'hff);
        host_u.wr_reg(mdc_pkg::OFS_WIN_DBC, 8'ha5);
        host_u.wr_reg(mdc_pkg::OFS_ST_DECIM, 8'h3c);
        host_u.wr_reg(mdc_pkg::OFS_OUT_DBC, 8'h5a);
        host_u.wr_reg(mdc_pkg::OFS_ST_IDLE, 8'h77);
        step(2);
        `CHK(lth, 12'h5ab)
        `CHK(uth, 12'h312)
        `CHK(odbc, 8'h5a)
        `CHK(wdbc, 8'ha5)
        `CHK(sidle, 8'h77)
        `CHK(sdecim, 8'h3c)
        host_u.rd_reg(mdc_pkg::OFS_LTH_HI, rv);
        `CHK(rv, 8'h05)
        bos = 1'b1;
        host_u.rd_reg(mdc_pkg::OFS_LTH_LO, rv);
        `CHK(rv, 8'h5a)
        host_u.rd_reg(mdc_pkg::OFS_UTH_HI, rv);
        `CHK(rv, 8'h20)
        bos = 1'b0;
        host_u.rd_reg(mdc_pkg::OFS_OUT_FLAGS, rv);
        `CHK(rv, 8'h00)
        host_u.rd_reg(mdc_pkg::OFS_WIN_DBC, rv);
        `CHK(rv, 8'ha5)
        host_u.rd_reg(mdc_pkg::OFS_ST_DECIM, rv);
        `CHK(rv, 8'h3c)
        $display("test read write done");
    endtask : t_rw
    // run entry clears flags and pulses buffer invalid; protected writes are dropped
    task t_active;
        evt.outside_threshold = 8'h81;
        step(1);
        evt = '0;
        step(2);
        `CHK(oflags, 8'h81)
        mode = mdc_pkg::MDC_ACTIVE;
        step(1);
        `CHK(binv, 1'b1)
        step(1);
        `CHK(binv, 1'b0)
        `CHK(oflags, 8'h00)
        host_u.wr_reg(mdc_pkg::OFS_CFG_A, 8'hff);
        host_u.wr_reg(mdc_pkg::OFS_CFG_B, 8'h07);
        host_u.wr_reg(mdc_pkg::OFS_CFG_B, 8'h20);
        mode = mdc_pkg::MDC_EXTERNAL_TRIGGER_MODE;
        host_u.wr_reg(mdc_pkg::OFS_ORIENT_THS, 8'h00);
        step(2);
        `CHK(cfg_a, 8'h38)
        `CHK(cfg_b, 8'hf8)
        `CHK(orient, 8'h84)
        mode = mdc_pkg::MDC_STANDBY;
        evt.within_threshold = 8'h3c;
        step(1);
        evt = '0;
        mode = mdc_pkg::MDC_EXTERNAL_TRIGGER_MODE;
        step(1);
        `CHK(binv, 1'b1)
        step(1);
        `CHK(wflags, 8'h00)
        mode = mdc_pkg::MDC_STANDBY;
        host_u.rd_reg(mdc_pkg::OFS_CFG_B, rv);
        `CHK(rv, 8'hf8)
        $display("test active done");
    endtask : t_active
    // leaving hibernate reloads the strap-low defaults
    task t_hib;
        strap = 1'b0;
        step(4);
        hib = 1'b1;
        step(1);
        hib = 1'b0;
        step(8);
        `CHK(cfg_a, 8'h00)
        `CHK(cfg_b, 8'h00)
        `CHK(orient, 8'h84)
        `CHK(lth, 12'h000)
        `CHK(uth, 12'h000)
        `CHK(wdbc, 8'h00)
        `CHK(sdecim, 8'h00)
        $display("test hibernate done");
    endtask : t_hib
    // counts, verdict and end of run
    task print_verdict;
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    // main sequence: 10-cycle reset, wait out the 4-edge init, then the tests
    initial begin
        repeat (10) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        step(8);
        t_defaults;
        t_rw;
        t_active;
        t_hib;
        print_verdict;
    end
    // the tests need about 140 cycles; 20000 cycles means a hang
    initial begin
        #80000;
        err_count++;
        print_verdict;
    end
endmodule : mdc_regs_tb
`default_nettype wire
